// ### hw/serial_sensor_poller_consts.svh
// Register map, field positions, reset values and timing figures of the sensor poller
`ifndef SERIAL_SENSOR_POLLER_CONSTS_SVH
`define SERIAL_SENSOR_POLLER_CONSTS_SVH

// Clock and time base
`define CLK_HZ 25000000
`define CLK_PERIOD_NS 40
`define MS_NS 1000000

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_CYCLE 8'h04
`define OFF_TIMEOUT 8'h08
`define OFF_REQ 8'h0c
`define OFF_LEN 8'h10
`define OFF_SETPT 8'h14
`define OFF_VALUE 8'h18
`define OFF_STATUS 8'h1c
`define OFF_IRQ_STAT 8'h20
`define OFF_IRQ_EN 8'h24
`define OFF_IRQ_CLR 8'h28

// Control fields
`define CTRL_EN 0
`define CTRL_RETRY 1
`define CTRL_BAUD_LSB 2
`define CTRL_STOP2 6
`define CTRL_PAR_LSB 7
`define CTRL_DATA7 9
`define CTRL_HOLD_LSB 10
`define CTRL_WIDTH 13
`define HOLD_PERM 3'h6

// Length fields
`define LEN_REQ_LSB 0
`define LEN_ANS_LSB 4
`define LEN_SET_LSB 8
`define LEN_WIDTH 11

// Interrupt bits
`define IRQ_DONE 0
`define IRQ_COMERR 1
`define IRQ_LINEERR 2
`define IRQ_WIDTH 3

// Reset values
`define CTRL_RST 13'h0014
`define CYCLE_RST 16'h03e8
`define TIMEOUT_RST 16'h0064
`define LEN_RST 11'h000
`define OPEN_LOOP_VALUE 32'h8000_0000

`endif

// ### hw/serial_sensor_poller_pkg.sv
// Types shared by the sensor poller and its character link
package serial_sensor_poller_pkg;
    typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_e;
    typedef enum {ST_IDLE, ST_REQ, ST_WAIT, ST_SET} poll_state_e;
    typedef enum {RX_IDLE, RX_START, RX_BITS} rx_state_e;
endpackage

// ### hw/serial_char_link.sv
// Asynchronous character transmitter and receiver with selectable framing
`timescale 1ns/10ps
`include "serial_sensor_poller_consts.svh"
module serial_char_link import serial_sensor_poller_pkg::*; #(
    parameter int CLK_HZ = `CLK_HZ
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] baudSel,
    input wire logic twoStop,
    input wire logic [1:0] parity,
    input wire logic sevenBits,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic txd,
    input wire logic rxd,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic rxBad
);
    // Bit period in clocks for each selectable rate
    function automatic logic [16:0] baudDiv(input logic [3:0] sel);
        int rate;
        case (sel)
            4'h0: rate = 300;
            4'h1: rate = 600;
            4'h2: rate = 1200;
            4'h3: rate = 2400;
            4'h4: rate = 4800;
            4'h5: rate = 9600;
            4'h6: rate = 19200;
            4'h7: rate = 38400;
            4'h8: rate = 57600;
            default: rate = 115200;
        endcase
        return 17'(CLK_HZ / rate);
    endfunction

    // Parity bit over the active data bits
    function automatic logic parBit(input logic [7:0] d, input logic [1:0] par, input logic s7);
        logic [7:0] m;
        m = s7 ? {1'b0, d[6:0]} : d;
        return (par == PAR_ODD) ? ~^m : ^m;
    endfunction

    logic [16:0] div;
    logic [3:0] pos;
    logic hasPar;
    logic [11:0] frame;
    logic [3:0] nbits;
    logic [3:0] rxNeed;
    logic [11:0] txShift_reg;
    logic [3:0] txLeft_reg;
    logic [16:0] txBaud_reg;
    logic txd_reg;
    logic rxS1_reg, rxS2_reg, rxPrev_reg;
    rx_state_e rxState_reg;
    logic [16:0] rxBaud_reg;
    logic [3:0] rxIdx_reg;
    logic [9:0] rxShift_reg;
    logic lastSample;
    logic rxGood;
    logic [7:0] rxWord;

    // Frame after the start bit: data, optional parity, stop bits idle high
    always_comb begin
        div = baudDiv(baudSel);
        hasPar = (parity != PAR_NONE);
        pos = sevenBits ? 4'h7 : 4'h8;
        frame = '1;
        frame[7:0] = sevenBits ? {1'b1, txData[6:0]} : txData;
        if (hasPar) begin
            frame[pos] = parBit(txData, parity, sevenBits);
        end
        nbits = 4'h1 + pos + {3'h0, hasPar} + (twoStop ? 4'h2 : 4'h1);
        rxNeed = pos + {3'h0, hasPar} + 4'h1;
    end

    assign txReady = (txLeft_reg == 4'h0);
    assign txd = txd_reg;

    // Transmit shifter; line rests high between characters
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            txShift_reg <= '1;
            txLeft_reg <= 4'h0;
            txBaud_reg <= 17'h0;
            txd_reg <= 1'b1;
        end else if (txLeft_reg == 4'h0) begin
            if (txValid) begin
                txd_reg <= 1'b0;
                txShift_reg <= frame;
                txLeft_reg <= nbits;
                txBaud_reg <= div - 17'h1;
            end
        end else if (txBaud_reg == 17'h0) begin
            txBaud_reg <= div - 17'h1;
            txLeft_reg <= txLeft_reg - 4'h1;
            txd_reg <= (txLeft_reg > 4'h1) ? txShift_reg[0] : 1'b1;
            txShift_reg <= {1'b1, txShift_reg[11:1]};
        end else begin
            txBaud_reg <= txBaud_reg - 17'h1;
        end
    end

    // Two-stage synchroniser; edges are seen only after the second stage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxS1_reg <= 1'b1;
            rxS2_reg <= 1'b1;
            rxPrev_reg <= 1'b1;
        end else begin
            rxS1_reg <= rxd;
            rxS2_reg <= rxS1_reg;
            rxPrev_reg <= rxS2_reg;
        end
    end

    assign lastSample = (rxState_reg == RX_BITS) && (rxBaud_reg == 17'h0) &&
                        (rxIdx_reg == rxNeed - 4'h1);

    // Receive sequencer: find start edge, recheck at mid-bit, then sample each bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxState_reg <= RX_IDLE;
            rxBaud_reg <= 17'h0;
            rxIdx_reg <= 4'h0;
            rxShift_reg <= '0;
        end else begin
            case (rxState_reg)
                RX_IDLE: begin
                    if (rxPrev_reg && !rxS2_reg) begin
                        rxState_reg <= RX_START;
                        rxBaud_reg <= {1'b0, div[16:1]};
                    end
                end
                RX_START: begin
                    if (rxBaud_reg != 17'h0) begin
                        rxBaud_reg <= rxBaud_reg - 17'h1;
                    end else if (!rxS2_reg) begin
                        rxState_reg <= RX_BITS;
                        rxBaud_reg <= div - 17'h1;
                        rxIdx_reg <= 4'h0;
                    end else begin
                        rxState_reg <= RX_IDLE;
                    end
                end
                RX_BITS: begin
                    if (rxBaud_reg != 17'h0) begin
                        rxBaud_reg <= rxBaud_reg - 17'h1;
                    end else begin
                        rxBaud_reg <= div - 17'h1;
                        rxShift_reg[rxIdx_reg] <= rxS2_reg;
                        rxIdx_reg <= rxIdx_reg + 4'h1;
                        if (lastSample) begin
                            rxState_reg <= RX_IDLE;
                        end
                    end
                end
                default: rxState_reg <= RX_IDLE;
            endcase
        end
    end

    // Only the first stop bit is checked, so two-stop senders are also accepted
    always_comb begin
        rxWord = sevenBits ? {1'b0, rxShift_reg[6:0]} : rxShift_reg[7:0];
        rxGood = rxS2_reg;
        if (hasPar && (rxShift_reg[pos] != parBit(rxWord, parity, sevenBits))) begin
            rxGood = 1'b0;
        end
    end

    // One-cycle result strobes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxData <= 8'h0;
            rxValid <= 1'b0;
            rxBad <= 1'b0;
        end else begin
            rxValid <= lastSample && rxGood;
            rxBad <= lastSample && !rxGood;
            if (lastSample) begin
                rxData <= rxWord;
            end
        end
    end
endmodule // serial_char_link

// ### hw/serial_sensor_poller.sv
// Periodic serial sensor poller with retry, hold and open-loop marking, APB registers
`timescale 1ns/10ps
`include "serial_sensor_poller_consts.svh"

// Behaviour
// - When a measurement is due the request bytes are sent out on the serial port.
// - With retry on, a request left unanswered at timeout is sent once more.
// - When the last attempt also times out with hold off or no good value yet, the channel takes the open-loop error value.
// - After every answer or failure the setpoint record, when its length is not zero, is sent on the same port.
// - The bit rate is chosen from ten rates between 300 and 115200 baud.
// - One or two stop bits are selectable for sending; on receive only the first stop bit is checked.
// - Parity is none, odd or even, generated on send and checked on receive.
// - Characters carry seven or eight data bits, matching the sensor.
// - A full answer must arrive within the timeout, zero meaning no timeout.
// - A hold count of one to five keeps the last good value that many failed cycles.
// - Permanent hold keeps the last good value; hold off shows errors at once.
// - With retry the request is repeated exactly once and only then an error is raised.
module serial_sensor_poller import serial_sensor_poller_pkg::*; #(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS,
    parameter logic [31:0] OPEN_LOOP = `OPEN_LOOP_VALUE
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    output logic irq,
    output logic [31:0] chanValue,
    output logic chanOpenLoop
);
    // Known register offsets, shared by read and write decode
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            `OFF_CTRL, `OFF_CYCLE, `OFF_TIMEOUT, `OFF_REQ, `OFF_LEN, `OFF_SETPT,
            `OFF_VALUE, `OFF_STATUS, `OFF_IRQ_STAT, `OFF_IRQ_EN, `OFF_IRQ_CLR: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    logic [`CTRL_WIDTH-1:0] ctrl_reg;
    logic [15:0] cycle_reg;
    logic [15:0] timeout_reg;
    logic [31:0] req_reg;
    logic [`LEN_WIDTH-1:0] len_reg;
    logic [31:0] setpt_reg;
    logic [`IRQ_WIDTH-1:0] irqStat_reg, irqStat_next, irqEn_reg, irqEvt;
    logic [31:0] rdMux;
    logic [24:0] tick_reg;
    logic msTick;
    logic [15:0] cycleCnt_reg, toCnt_reg;
    poll_state_e state_reg;
    logic [2:0] byteIdx_reg;
    logic [1:0] ansCnt_reg;
    logic [23:0] ansBuf_reg;
    logic attempt_reg;
    logic haveValid_reg;
    logic [2:0] holdCnt_reg;
    logic setup, wrAcc, portOn, due, expired, ansDone, failEvt, retryEvt;
    logic txValid, txReady;
    logic [7:0] txByte, rxData;
    logic rxValid, rxBad;
    logic [2:0] reqLen, ansLen, setLen, hold;
    logic [1:0] stateCode;

    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pready && pwrite && mapped(paddr);
    assign portOn = ctrl_reg[`CTRL_EN];
    assign reqLen = {1'b0, len_reg[`LEN_REQ_LSB +: 2]} + 3'h1;
    assign ansLen = {1'b0, len_reg[`LEN_ANS_LSB +: 2]} + 3'h1;
    assign setLen = len_reg[`LEN_SET_LSB +: 3];
    assign hold = ctrl_reg[`CTRL_HOLD_LSB +: 3];

    // Software-written configuration; writes land only on the completing access edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RST;
            cycle_reg <= `CYCLE_RST;
            timeout_reg <= `TIMEOUT_RST;
            req_reg <= 32'h0;
            len_reg <= `LEN_RST;
            setpt_reg <= 32'h0;
            irqEn_reg <= '0;
        end else if (wrAcc) begin
            case (paddr)
                `OFF_CTRL: ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
                `OFF_CYCLE: cycle_reg <= pwdata[15:0];
                `OFF_TIMEOUT: timeout_reg <= pwdata[15:0];
                `OFF_REQ: req_reg <= pwdata;
                `OFF_LEN: len_reg <= pwdata[`LEN_WIDTH-1:0];
                `OFF_SETPT: setpt_reg <= pwdata;
                `OFF_IRQ_EN: irqEn_reg <= pwdata[`IRQ_WIDTH-1:0];
                default: irqEn_reg <= irqEn_reg;
            endcase
        end
    end

    // Read multiplexer; write-only clear reads as zero
    always_comb begin
        stateCode = 2'h0;
        case (state_reg)
            ST_REQ: stateCode = 2'h1;
            ST_WAIT: stateCode = 2'h2;
            ST_SET: stateCode = 2'h3;
            default: stateCode = 2'h0;
        endcase
        case (paddr)
            `OFF_CTRL: rdMux = {19'h0, ctrl_reg};
            `OFF_CYCLE: rdMux = {16'h0, cycle_reg};
            `OFF_TIMEOUT: rdMux = {16'h0, timeout_reg};
            `OFF_REQ: rdMux = req_reg;
            `OFF_LEN: rdMux = {21'h0, len_reg};
            `OFF_SETPT: rdMux = setpt_reg;
            `OFF_VALUE: rdMux = chanValue;
            `OFF_STATUS: rdMux = {24'h0, holdCnt_reg, chanOpenLoop, attempt_reg, haveValid_reg,
                                  stateCode};
            `OFF_IRQ_STAT: rdMux = {29'h0, irqStat_reg};
            `OFF_IRQ_EN: rdMux = {29'h0, irqEn_reg};
            default: rdMux = 32'h0;
        endcase
    end

    // APB answer: data captured in setup, pready high in the first access cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped(paddr);
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rdMux;
            end
        end
    end

    // Millisecond time base
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_reg <= 25'h0;
        end else begin
            tick_reg <= msTick ? 25'h0 : tick_reg + 25'h1;
        end
    end
    assign msTick = (tick_reg == 25'(MS_CYCLES - 1));

    // Measurement cycle timer, held at zero while the port is off
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cycleCnt_reg <= 16'h0;
        end else if (!portOn || due) begin
            cycleCnt_reg <= 16'h0;
        end else if (msTick) begin
            cycleCnt_reg <= cycleCnt_reg + 16'h1;
        end
    end
    // A poll still running when the cycle ends makes that cycle be skipped
    assign due = portOn && msTick && (cycleCnt_reg + 16'h1 >= cycle_reg);

    // Frame timeout counted in ms from the start of the last request byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            toCnt_reg <= 16'h0;
        end else if (state_reg != ST_WAIT) begin
            toCnt_reg <= 16'h0;
        end else if (msTick) begin
            toCnt_reg <= toCnt_reg + 16'h1;
        end
    end
    assign expired = (state_reg == ST_WAIT) && (timeout_reg != 16'h0) && msTick &&
                     (toCnt_reg + 16'h1 == timeout_reg);
    assign ansDone = (state_reg == ST_WAIT) && rxValid && ({1'b0, ansCnt_reg} == ansLen - 3'h1);
    assign retryEvt = expired && ctrl_reg[`CTRL_RETRY] && !attempt_reg;
    assign failEvt = expired && !retryEvt;

    // Byte offered to the transmitter; low byte goes first
    assign txValid = (state_reg == ST_REQ) || ((state_reg == ST_SET) && (setLen != 3'h0));
    assign txByte = (state_reg == ST_SET) ? setpt_reg[{byteIdx_reg[1:0], 3'h0} +: 8]
                                          : req_reg[{byteIdx_reg[1:0], 3'h0} +: 8];

    // Poll sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            byteIdx_reg <= 3'h0;
            attempt_reg <= 1'b0;
            ansCnt_reg <= 2'h0;
            ansBuf_reg <= 24'h0;
        end else if (!portOn) begin
            state_reg <= ST_IDLE;
            byteIdx_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (due) begin
                        state_reg <= ST_REQ;
                        byteIdx_reg <= 3'h0;
                        attempt_reg <= 1'b0;
                    end
                end
                ST_REQ: begin
                    if (txReady) begin
                        byteIdx_reg <= byteIdx_reg + 3'h1;
                        if (byteIdx_reg == reqLen - 3'h1) begin
                            state_reg <= ST_WAIT;
                            ansCnt_reg <= 2'h0;
                            ansBuf_reg <= 24'h0;
                        end
                    end
                end
                ST_WAIT: begin
                    if (ansDone || failEvt) begin
                        state_reg <= ST_SET;
                        byteIdx_reg <= 3'h0;
                    end else if (retryEvt) begin
                        state_reg <= ST_REQ;
                        byteIdx_reg <= 3'h0;
                        attempt_reg <= 1'b1;
                    end else if (rxValid) begin
                        ansCnt_reg <= ansCnt_reg + 2'h1;
                        ansBuf_reg <= {ansBuf_reg[15:0], rxData};
                    end
                end
                ST_SET: begin
                    if (setLen == 3'h0) begin
                        state_reg <= ST_IDLE;
                    end else if (txReady) begin
                        byteIdx_reg <= byteIdx_reg + 3'h1;
                        if (byteIdx_reg == setLen - 3'h1) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Channel value: good answers load it, failures hold it or mark it open-loop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chanValue <= OPEN_LOOP;
            chanOpenLoop <= 1'b1;
            haveValid_reg <= 1'b0;
            holdCnt_reg <= 3'h0;
        end else if (ansDone) begin
            chanValue <= {ansBuf_reg, rxData};
            chanOpenLoop <= 1'b0;
            haveValid_reg <= 1'b1;
            holdCnt_reg <= 3'h0;
        end else if (failEvt) begin
            if (!haveValid_reg || hold == 3'h0) begin
                chanValue <= OPEN_LOOP;
                chanOpenLoop <= 1'b1;
            end else if (hold >= `HOLD_PERM) begin
                chanValue <= chanValue;
            end else if (holdCnt_reg < hold) begin
                holdCnt_reg <= holdCnt_reg + 3'h1;
            end else begin
                chanValue <= OPEN_LOOP;
                chanOpenLoop <= 1'b1;
            end
        end
    end

    // Sticky event flags; a new event wins over a clear in the same cycle
    assign irqEvt = {rxBad, failEvt, ansDone};
    always_comb begin
        irqStat_next = irqStat_reg;
        if (wrAcc && paddr == `OFF_IRQ_CLR) begin
            irqStat_next = irqStat_reg & ~pwdata[`IRQ_WIDTH-1:0];
        end
        irqStat_next = irqStat_next | irqEvt;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqStat_reg <= '0;
            irq <= 1'b0;
        end else begin
            irqStat_reg <= irqStat_next;
            irq <= |(irqStat_reg & irqEn_reg);
        end
    end

    serial_char_link #(
        .CLK_HZ(CLK_HZ)
    ) u_link (
        .mclk(mclk),
        .rst(rst),
        .baudSel(ctrl_reg[`CTRL_BAUD_LSB +: 4]),
        .twoStop(ctrl_reg[`CTRL_STOP2]),
        .parity(ctrl_reg[`CTRL_PAR_LSB +: 2]),
        .sevenBits(ctrl_reg[`CTRL_DATA7]),
        .txData(txByte),
        .txValid(txValid),
        .txReady(txReady),
        .txd(txd),
        .rxd(rxd),
        .rxData(rxData),
        .rxValid(rxValid),
        .rxBad(rxBad)
    );
endmodule // serial_sensor_poller

// ### bench/serial_sensor_poller_checker.sv
// Port assertions for the sensor poller
`timescale 1ns/10ps
module serial_sensor_poller_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic irq,
    input wire logic [31:0] chanValue,
    input wire logic chanOpenLoop
);
    logic ienZero;
    // Mask mirror, since the enable register is only seen on the bus
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ienZero <= 1'b1;
        end else if (psel && penable && pready && pwrite && paddr == 8'h24) begin
            ienZero <= pwdata[2:0] == 3'h0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Bench bit time is ten clocks, so eight is a safe floor
    sequence s_setup; psel && !penable; endsequence
    sequence s_lowBit; (!txd) [*8]; endsequence
    sequence s_highBit; txd [*8]; endsequence
    property p_readyNext; s_setup |=> pready && penable; endproperty
    property p_readyOnce; pready |=> !pready; endproperty
    property p_errMap;
        pslverr |-> pready && (paddr[1:0] != 2'h0 || paddr > 8'h28) && prdata == 32'h0;
    endproperty
    property p_startBit; $fell(txd) |-> s_lowBit; endproperty
    property p_highBit; $rose(txd) |-> s_highBit; endproperty
    property p_olFlag; chanOpenLoop |-> chanValue == 32'h8000_0000; endproperty
    property p_irqMask; ienZero |=> !irq; endproperty
    property p_quiet; $changed(chanValue) && !chanOpenLoop |-> txd && rxd; endproperty
    a_readyNext: assert property (p_readyNext) else $error("ready late");
    a_readyOnce: assert property (p_readyOnce) else $error("ready held");
    a_errMap: assert property (p_errMap) else $error("bad slave error");
    a_startBit: assert property (p_startBit) else $error("start bit short");
    a_highBit: assert property (p_highBit) else $error("high bit short");
    a_olFlag: assert property (p_olFlag) else $error("flag without value");
    a_irqMask: assert property (p_irqMask) else $error("masked irq");
    a_quiet: assert property (p_quiet) else $error("value moved early");
endmodule // serial_sensor_poller_checker
bind serial_sensor_poller serial_sensor_poller_checker i_chk (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
    .irq(irq), .chanValue(chanValue), .chanOpenLoop(chanOpenLoop));

// ### bench/sensor_model.sv
// Sensor on the far end of the line, 8 data bits, no parity, one stop bit
`timescale 1ns/10ps
module sensor_model #(
    parameter int BIT = 10
) (
    input wire logic mclk,
    input wire logic txd,
    output logic rxd
);
    logic answerOn = 1'b0;
    logic [7:0] ansByte = 8'h00;
    logic [7:0] got;
    logic [9:0] frame;
    int reqCount = 0;
    int setCount = 0;
    // Sample at bit centres, answer only the request byte
    initial begin
        rxd = 1'b1;
        forever begin
            @(negedge txd);
            repeat (BIT + BIT / 2) @(posedge mclk);
            for (int i = 0; i < 8; i++) begin
                got[i] = txd;
                repeat (BIT) @(posedge mclk);
            end
            if (got == 8'h3c) setCount++;
            if (got == 8'h5a) begin
                reqCount++;
                if (answerOn) begin
                    frame = {1'b1, ansByte, 1'b0};
                    repeat (2 * BIT) @(posedge mclk);
                    for (int i = 0; i < 10; i++) begin
                        rxd <= frame[i];
                        repeat (BIT) @(posedge mclk);
                    end
                end
            end
        end
    end
endmodule // sensor_model

// ### bench/serial_sensor_poller_tb_top.sv
// Bench for the sensor poller: bus tasks and table-driven polling rounds
`timescale 1ns/10ps
module serial_sensor_poller_tb_top;
    localparam logic [31:0] ERRV = 32'h8000_0000;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, chanValue, rd;
    logic pready, pslverr, rxd, txd, irq, chanOpenLoop, err;
    logic [31:0] ctrl [9] = '{32'h25, 32'h27, 32'h825, 32'h825, 32'h825, 32'h825,
        32'h1825, 32'h1825, 32'h1825};
    logic ans [9] = '{1, 0, 1, 0, 0, 0, 1, 0, 0};
    logic [31:0] val [9] = '{32'ha7, ERRV, 32'h96, 32'h96, 32'h96, ERRV, 32'hc3, 32'hc3, 32'hc3};
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int reqs;
    int sets;
    serial_sensor_poller #(.CLK_HZ(1152000), .MS_CYCLES(10)) i_serial_sensor_poller (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd(rxd), .txd(txd), .irq(irq), .chanValue(chanValue), .chanOpenLoop(chanOpenLoop));
    sensor_model #(.BIT(10)) i_sensor_model (.mclk(mclk), .txd(txd), .rxd(rxd));
    initial begin
        forever #20 mclk = ~mclk;
    end
    // Watchdog well above the roughly 12000 cycles the rounds need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One bus transfer, held until ready is seen; only the watchdog ends a wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check("register", rd, e);
    endtask
    task automatic close_out();
        $display("Compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reset, register defaults, then one table row per measurement cycle
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        check("reset value", chanValue, ERRV);
        rdchk(8'h00, 32'h14);
        rdchk(8'h08, 32'h64);
        rdchk(8'h40, 32'h0);
        check("slave error", {31'h0, err}, 32'h1);
        xfer(1'b1, 8'h04, 32'd100);
        xfer(1'b1, 8'h08, 32'd25);
        xfer(1'b1, 8'h0c, 32'h5a);
        xfer(1'b1, 8'h10, 32'h100);
        xfer(1'b1, 8'h14, 32'h3c);
        xfer(1'b1, 8'h24, 32'h3); // Done and comm error both raise the line
        for (int i = 0; i < 9; i++) begin
            if (i == 0 || ctrl[i] != ctrl[i - 1]) xfer(1'b1, 8'h00, ctrl[i]);
            i_sensor_model.answerOn = ans[i];
            i_sensor_model.ansByte = val[i][7:0];
            reqs = i_sensor_model.reqCount;
            sets = i_sensor_model.setCount;
            for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge mclk);
            check("irq", {31'h0, irq}, 32'h1);
            rdchk(8'h20, ans[i] ? 32'h1 : 32'h2);
            xfer(1'b1, 8'h28, 32'h7);
            // Let the setpoint record finish before counting it
            repeat (200) @(posedge mclk);
            check("value", chanValue, val[i]);
            check("flag", {31'h0, chanOpenLoop}, {31'h0, val[i] == ERRV});
            check("requests", i_sensor_model.reqCount - reqs, ctrl[i][1] ? 2 : 1);
            check("setpoints", i_sensor_model.setCount - sets, 1);
        end
        xfer(1'b1, 8'h00, 32'h24);
        reqs = i_sensor_model.reqCount;
        repeat (2500) @(posedge mclk);
        check("port off", i_sensor_model.reqCount - reqs, 0);
        close_out();
    end
endmodule // serial_sensor_poller_tb_top
